/* File: bench/adc_seq_assertions.sv */
// Port-level checks of the conversion sequence controller
`timescale 1ns/10ps
module adc_seq_checker (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [3:0] CHANNEL,
    input wire logic SAMPLE,
    input wire logic SEQ_START,
    input wire logic RESULT_VALID
);
    logic wr;
    // ==========================================================
    // Control write taken on the bus
    assign wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    a_write_start: assert property (wr |=> SAMPLE && SEQ_START
        && CHANNEL == $past(PWDATA[3:0])) else $error("write did not start");
    a_sample_len: assert property (disable iff (!RESETN || wr)
        $rose(SAMPLE) |-> SAMPLE[*4] ##1 !SAMPLE) else $error("sample length");
    a_valid_delay: assert property (disable iff (!RESETN || wr)
        $fell(SAMPLE) |-> ##10 RESULT_VALID) else $error("result late");
    a_chan_hold: assert property (disable iff (!RESETN || wr)
        $fell(SAMPLE) |-> $stable(CHANNEL)[*8]) else $error("channel moved");
    a_valid_pulse: assert property (RESULT_VALID |=> !RESULT_VALID)
        else $error("result pulse");
    a_start_pulse: assert property (SEQ_START |-> SAMPLE ##1 !SEQ_START)
        else $error("start pulse");
    a_bus_ready: assert property (PSEL && PENABLE |-> PREADY)
        else $error("not ready");
    a_addr_map: assert property (PSEL && PENABLE |-> PSLVERR ==
        (PADDR != 12'h000 && PADDR != 12'h004 && PADDR != 12'h008)) else $error("map");
endmodule
bind adc_sequence_control adc_seq_checker i_chk (.CLOCK(CLOCK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CHANNEL(CHANNEL), .SAMPLE(SAMPLE),
    .SEQ_START(SEQ_START), .RESULT_VALID(RESULT_VALID));

/* File: bench/conv_front_model.sv */
// Converter front end model: channel-coded samples and trigger pulses
`timescale 1ns/10ps
module conv_front_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] channel,
    input wire logic sample,
    input wire logic fire,
    output logic [9:0] conv_data,
    output logic ext_trigger
);
    logic [3:0] ch_q;
    logic [1:0] cnt_q;
    // ==========================================================
    // Channel capture and trigger stretch
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ch_q <= 4'h0;
            cnt_q <= 2'h0;
        end else begin
            if (sample) begin
                ch_q <= channel;
            end
            if (fire) begin
                cnt_q <= 2'h3;
            end else if (cnt_q != 2'h0) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
    // Code carries the channel; unsettled while sampling, so inverted
    assign conv_data = sample ? ~{ch_q, 6'h15} : {ch_q, 6'h15};
    // Held three cycles to pass the input synchroniser
    assign ext_trigger = cnt_q != 2'h0;
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the conversion sequence controller
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", n, e, a); end end
module testbench;
    logic CLOCK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic fire = 1'b0, err, PREADY, PSLVERR, EXT_TRIGGER, SAMPLE, SEQ_START;
    logic RESULT_VALID, SEQ_DONE;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [9:0] CONV_DATA;
    logic [3:0] CHANNEL;
    logic [15:0] RESULT;
    int fail_count = 0;
    int cmp_count = 0;
    // ==========================================================
    // Clock, design and far side
    always #12.5 CLOCK = ~CLOCK;
    adc_sequence_control i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_TRIGGER(EXT_TRIGGER),
        .CONV_DATA(CONV_DATA), .CHANNEL(CHANNEL), .SAMPLE(SAMPLE), .SEQ_START(SEQ_START),
        .RESULT(RESULT), .RESULT_VALID(RESULT_VALID), .SEQ_DONE(SEQ_DONE));
    conv_front_model i_front (.clock(CLOCK), .resetn(RESETN), .channel(CHANNEL),
        .sample(SAMPLE), .fire(fire), .conv_data(CONV_DATA), .ext_trigger(EXT_TRIGGER));
    // ==========================================================
    // Helpers: result layout, bus cycle, waits
    function automatic logic [15:0] fmt(logic [3:0] c, logic j, logic s);
        logic [9:0] r;
        r = {c, 6'h15};
        if (j) return {6'h00, r};
        if (s) return {~r[9], r[8:0], 6'h00};
        return {r, 6'h00};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) @(posedge CLOCK);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wctl(input logic [7:0] v);
        apb(1'b1, 12'h000, {24'h0, v});
        @(negedge CLOCK);
        `CHK("sample", 1'b1, SAMPLE)
        `CHK("channel", v[3:0], CHANNEL)
    endtask
    task automatic wait_res(input logic [3:0] c, input logic j, s, dn);
        int k;
        k = 0;
        @(negedge CLOCK);
        while (RESULT_VALID !== 1'b1 && k < 60) begin
            @(negedge CLOCK);
            k++;
        end
        `CHK("valid", 1'b1, RESULT_VALID)
        `CHK("result", fmt(c, j, s), RESULT)
        `CHK("done", dn, SEQ_DONE)
    endtask
    task automatic no_res(input int n);
        repeat (n) begin
            @(negedge CLOCK);
            `CHK("idle", 1'b0, RESULT_VALID)
        end
    endtask
    task automatic pulse();
        @(posedge CLOCK);
        fire <= 1'b1;
        @(posedge CLOCK);
        fire <= 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("cfg reset", 32'h4, rd)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("status idle", 32'h1, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", 1'b1, err)
    endtask
    task automatic t_format();
        for (int i = 0; i < 4; i++) begin
            wctl({i[1:0], 6'h05});
            repeat (3) wait_res(4'h5, i[1], i[0], 1'b0);
            wait_res(4'h5, i[1], i[0], 1'b1);
        end
    endtask
    task automatic t_abort();
        wctl(8'h03);
        repeat (8) @(posedge CLOCK);
        wctl(8'h09);
        wait_res(4'h9, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_multi();
        apb(1'b1, 12'h004, 32'h3);
        wctl(8'h9e);
        wait_res(4'he, 1'b1, 1'b0, 1'b0);
        wait_res(4'hf, 1'b1, 1'b0, 1'b0);
        wait_res(4'h0, 1'b1, 1'b0, 1'b1);
        no_res(20);
    endtask
    task automatic t_scan_trig();
        apb(1'b1, 12'h004, 32'h1);
        wctl(8'h22);
        repeat (2) wait_res(4'h2, 1'b0, 1'b0, 1'b1);
        apb(1'b1, 12'h004, 32'h101);
        wait_res(4'h2, 1'b0, 1'b0, 1'b1);
        pulse();
        no_res(40);
        wctl(8'h27);
        wait_res(4'h7, 1'b0, 1'b0, 1'b1);
        no_res(40);
        pulse();
        wait_res(4'h7, 1'b0, 1'b0, 1'b1);
        no_res(40);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl readback", 32'h27, rd)
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge CLOCK);
        RESETN <= 1'b1;
        t_regs();
        t_format();
        t_abort();
        t_multi();
        t_scan_trig();
        finish_test();
    end
    // Watchdog, well beyond the expected run of under a thousand cycles
    initial begin
        repeat (4000) @(posedge CLOCK);
        fail_count++;
        finish_test();
    end
endmodule

/* File: hdl/adc_seq_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sequence controller
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ==========================================================
// Register map (byte addresses, one aligned word each)
`define SEQ_CTRL_ADDR 12'h000
`define SEQ_CFG_ADDR 12'h004
`define SEQ_STATUS_ADDR 12'h008

// ==========================================================
// Field positions of the sequence control register
`define FLD_JUSTIFY 7
`define FLD_SIGNED 6
`define FLD_SCAN 5
`define FLD_MULTI 4
`define FLD_CHAN_HI 3
`define FLD_CHAN_LO 0

// ==========================================================
// Field positions of the sequence configuration register
`define FLD_LEN_HI 3
`define FLD_LEN_LO 0
`define FLD_ETRIG 8

// ==========================================================
// Reset values
`define SEQ_CTRL_RESET 8'h00
`define SEQ_LEN_RESET 4'h4
`define ETRIG_RESET 1'b0

// ==========================================================
// Timing counts in CLOCK cycles
`define SAMPLE_CYCLES 4
`define CONVERT_CYCLES 10

`endif

/* File: hdl/adc_seq_pkg.sv */
// Types shared by the conversion sequence controller
package adc_seq_pkg;

    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_t;

    typedef logic [3:0] chan_t;

endpackage

/* File: hdl/adc_sequence_control.sv */
// Conversion sequence controller with APB registers
// Contract
// - Any control write aborts the running sequence and starts a new one.
// - With external trigger, one control write arms; each trigger then starts a sequence.
// - Start of conversion is the start of the sampling phase.
// - Bit 7: 0 left justified result, 1 right justified.
// - Bit 6: 0 unsigned, 1 signed two's complement result.
// - Signed format only when left justified; right justified is unsigned.
// - Bit 5: 0 single sequence, 1 continuous scan.
// - With external trigger, scan ignored; each trigger starts one sequence.
// - Bit 4 low: every conversion samples the selected channel.
// - Bit 4 high: converts sequence-length channels.
// - Multi-channel starts at selected code, increments, wraps to channel 0.
// - Control register readable and writable at any time.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "adc_seq_cfg.svh"

// ==========================================================
// Register map, one aligned 32-bit word each
//   0x000 control byte: bit 7 right justify, bit 6 signed, bit 5 scan,
//         bit 4 multi-channel, bits 3:0 channel code; bits 31:8 read 0
//   0x004 configuration: bits 3:0 sequence length, bit 8 trigger enable
//   0x008 status, read only: bit 0 idle, bit 1 busy, bit 2 armed,
//         bits 11:8 channel being worked on
//   Other addresses answer with an error; writes there are dropped
//
// ==========================================================
// Bus timing
//   No wait states: every access phase completes in one cycle.
//   Read data loads on the setup edge, so it is steady for the whole
//   access phase and holds until the next read.
//   A write takes effect on the edge that completes the access phase.
//
// ==========================================================
// Sequence timing, counted from the edge that takes a start
//   cycle 1       sampling phase begins, start pulse, channel shown
//   cycles 1-4    sampling phase
//   cycles 5-14   conversion phase
//   cycle 15      result with valid pulse, done pulse on the last one
//   The next conversion of a sequence begins in cycle 15 as well, so
//   conversions run back to back without a gap.
//
// ==========================================================
// Limitations
//   A sequence length of zero runs one conversion.
//   A start during a conversion throws that conversion away; a
//   partial result is never reported.
//   The trigger pin passes a two-stage synchroniser, so a pulse must
//   stay high for more than one clock period or it may be missed.
//   Trigger starts wait for one control write; disabling the trigger
//   input drops that arming again.
//   Scan mode is ignored while the trigger input is enabled, so each
//   trigger yields exactly one sequence.
//   The converter sample is taken on the last conversion cycle; the
//   front end must hold it steady then.
//   Control settings change only through a write, which always
//   restarts the sequence, so a running sequence never mixes formats.

module adc_sequence_control
    import adc_seq_pkg::*;
#(
    parameter int RES_BITS = 10,
    parameter int NUM_CHANNELS = 16
) (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_TRIGGER,
    input wire logic [RES_BITS-1:0] CONV_DATA,
    output logic [3:0] CHANNEL,
    output logic SAMPLE,
    output logic SEQ_START,
    output logic [15:0] RESULT,
    output logic RESULT_VALID,
    output logic SEQ_DONE
);
    import adc_seq_pkg::*;

    // Refuse parameter values the counters and formatter cannot serve
    initial begin
        if (NUM_CHANNELS < 2 || NUM_CHANNELS > 16) begin
            $error("adc_sequence_control: NUM_CHANNELS must be 2..16");
        end
        if (RES_BITS < 2 || RES_BITS > 16) begin
            $error("adc_sequence_control: RES_BITS must be 2..16");
        end
    end

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] base);
        hit = (addr == base);
    endfunction

    // Bus side
    logic wr_en;
    logic ctrl_wr;
    logic cfg_wr;
    logic mapped;
    // Configuration and arming
    logic [7:0] ctrl_q;
    logic [3:0] len_q;
    logic etrig_en_q;
    logic armed_q;
    // Trigger path
    logic trig_s1_q;
    logic trig_s2_q;
    logic trig_s3_q;
    logic trig_rise;
    // Sequencer
    seq_state_t state_q;
    logic [3:0] chan_q;
    logic [3:0] remain_q;
    logic [4:0] cnt_q;
    logic start_req;
    logic last_conv;
    // Formatter output
    logic [15:0] fmt;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign ctrl_wr = wr_en && hit(PADDR, `SEQ_CTRL_ADDR);
    assign cfg_wr = wr_en && hit(PADDR, `SEQ_CFG_ADDR);
    assign mapped = hit(PADDR, `SEQ_CTRL_ADDR) || hit(PADDR, `SEQ_CFG_ADDR)
        || hit(PADDR, `SEQ_STATUS_ADDR);

    // Zero wait states; unmapped addresses flag an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // ==========================================================
    // Registers: writable any time, no state lockout
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= `SEQ_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= PWDATA[7:0];
        end
    end

    // Sequence length and trigger enable live outside the control byte
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            len_q <= `SEQ_LEN_RESET;
            etrig_en_q <= `ETRIG_RESET;
        end else if (cfg_wr) begin
            len_q <= PWDATA[`FLD_LEN_HI:`FLD_LEN_LO];
            etrig_en_q <= PWDATA[`FLD_ETRIG];
        end
    end

    // Read mux, registered so data is stable over the access phase
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            if (hit(PADDR, `SEQ_CTRL_ADDR)) begin
                PRDATA <= {24'h00_0000, ctrl_q};
            end else if (hit(PADDR, `SEQ_CFG_ADDR)) begin
                PRDATA <= {23'h00_0000, etrig_en_q, 4'h0, len_q};
            end else if (hit(PADDR, `SEQ_STATUS_ADDR)) begin
                PRDATA <= {16'h0000, 4'h0, chan_q, 5'h00, armed_q, state_q[2:1] != 2'b00,
                    state_q == ST_IDLE};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Trigger synchroniser; the first stage feeds only the second
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= EXT_TRIGGER;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end
    assign trig_rise = trig_s2_q && !trig_s3_q;

    // Trigger is only honoured after one control write
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            armed_q <= 1'b0;
        end else if (ctrl_wr) begin
            armed_q <= 1'b1;
        end else if (!etrig_en_q) begin
            armed_q <= 1'b0;
        end
    end

    // ==========================================================
    // Sequencer
    assign last_conv = (remain_q == 4'h1) || (remain_q == 4'h0);
    assign start_req = etrig_en_q && armed_q && trig_rise;

    // Channel after c, wrapping from the top channel back to zero
    function automatic logic [3:0] next_chan(input logic [3:0] c);
        if (c == 4'(NUM_CHANNELS - 1)) begin
            next_chan = 4'h0;
        end else begin
            next_chan = c + 4'h1;
        end
    endfunction

    // State, channel and counters; a start from bus or trigger overrides
    // everything else, which is what makes a write abort cleanly
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            chan_q <= 4'h0;
            remain_q <= 4'h0;
            cnt_q <= 5'h00;
        end else if (ctrl_wr || start_req) begin
            // Abort whatever runs; new settings take effect at once
            state_q <= ST_SAMPLE;
            chan_q <= ctrl_wr ? PWDATA[`FLD_CHAN_HI:`FLD_CHAN_LO]
                : ctrl_q[`FLD_CHAN_HI:`FLD_CHAN_LO];
            remain_q <= len_q;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 5'h00;
                end
                // Hold the sampling phase for its fixed count
                ST_SAMPLE: begin
                    if (cnt_q == 5'(`SAMPLE_CYCLES - 1)) begin
                        state_q <= ST_CONVERT;
                        cnt_q <= 5'h00;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                // End of conversion decides: next channel, rescan or stop
                ST_CONVERT: begin
                    if (cnt_q == 5'(`CONVERT_CYCLES - 1)) begin
                        cnt_q <= 5'h00;
                        if (ctrl_q[`FLD_MULTI]) begin
                            chan_q <= next_chan(chan_q);
                        end
                        if (!last_conv) begin
                            remain_q <= remain_q - 4'h1;
                            state_q <= ST_SAMPLE;
                        end else if (ctrl_q[`FLD_SCAN] && !etrig_en_q) begin
                            // Scan restarts from the selected channel
                            remain_q <= len_q;
                            chan_q <= ctrl_q[`FLD_CHAN_HI:`FLD_CHAN_LO];
                            state_q <= ST_SAMPLE;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Result formatting
    result_format #(
        .RES_BITS(RES_BITS)
    ) u_fmt (
        .raw(CONV_DATA),
        .justify_right(ctrl_q[`FLD_JUSTIFY]),
        .signed_mode(ctrl_q[`FLD_SIGNED]),
        .result(fmt)
    );

    // Outputs registered; data captured at end of each conversion
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            RESULT <= 16'h0000;
            RESULT_VALID <= 1'b0;
            SEQ_DONE <= 1'b0;
            SEQ_START <= 1'b0;
        end else begin
            SEQ_START <= ctrl_wr || start_req;
            RESULT_VALID <= 1'b0;
            SEQ_DONE <= 1'b0;
            if (!ctrl_wr && !start_req && state_q == ST_CONVERT
                && cnt_q == 5'(`CONVERT_CYCLES - 1)) begin
                RESULT <= fmt;
                RESULT_VALID <= 1'b1;
                SEQ_DONE <= last_conv;
            end
        end
    end

    // Channel and sampling phase straight from state, no extra delay
    assign CHANNEL = chan_q;
    assign SAMPLE = (state_q == ST_SAMPLE);

endmodule

/* File: hdl/result_format.sv */
// Formats a raw conversion into the result register layout
`timescale 1ns/10ps
`include "adc_seq_cfg.svh"

module result_format #(
    parameter int RES_BITS = 10
) (
    input wire logic [RES_BITS-1:0] raw,
    input wire logic justify_right,
    input wire logic signed_mode,
    output logic [15:0] result
);

    initial begin
        if (RES_BITS < 1 || RES_BITS > 16) begin
            $error("result_format: RES_BITS must be 1..16");
        end
    end

    // ==========================================================
    // Right justified always unsigned; signed only left justified
    always_comb begin
        logic [RES_BITS-1:0] val;
        val = raw;
        if (!justify_right && signed_mode) begin
            val = {~raw[RES_BITS-1], raw[RES_BITS-2:0]};
        end
        if (justify_right) begin
            result = {{(16-RES_BITS){1'b0}}, raw};
        end else begin
            result = {val, {(16-RES_BITS){1'b0}}};
        end
    end

endmodule
